// ---- setm_top.sv ----
// State event timer: registers, counters, state variables, actions
//
// Local design decisions: strobed register access and the register offsets.
module setm_top (
    // Clock and reset
    input  wire logic                         mclk,
    input  wire logic                         resetn,
    // Register port
    input  wire logic [7:0]                   addr,
    input  wire logic [31:0]                  wdata,
    input  wire logic                         wr,
    input  wire logic                         rd,
    output logic      [31:0]                  rdata,
    // Timer pins
    input  wire logic [setm_pkg::NIN-1:0]     in_pin,
    output logic      [setm_pkg::NOUT-1:0]    out_pin,
    output logic                              irq
);
    // =========================================================
    // State and event wiring
    setm_pkg::setm_state_s                  st;
    setm_pkg::setm_state_s                  next_st;
    logic [setm_pkg::NEV-1:0]               hit;
    logic [setm_pkg::NOUT-1:0]              out_lvl;
    logic [setm_pkg::NOUT-1:0]              out_chg;
    logic [setm_pkg::NIN-1:0]               in_rise;
    logic [setm_pkg::NIN-1:0]               in_fall;
    logic [1:0]                             halted;
    logic                                   unify;

    // Edges come from the second and third stages only
    assign in_rise = st.in_s2 & ~st.in_prev;
    assign in_fall = ~st.in_s2 & st.in_prev;
    assign halted  = st.ctrl[setm_pkg::C_HALT +: 2];
    assign unify   = st.ctrl[setm_pkg::C_UNIFY];

    assign rdata   = st.rdata;
    assign out_pin = st.outv;
    assign irq     = st.irq;

    // =========================================================
    // Event detectors and output resolvers
    for (genvar e = 0; e < setm_pkg::NEV; e++) begin : g_ev
        setm_event u_ev (
            .ctl       (st.evctl[e]),
            .state_en  (st.evst[e]),
            .match_val (st.match[st.evctl[e].msel]),
            .unify     (unify),
            .updown    (st.ctrl[setm_pkg::C_UD +: 2]),
            .down      (st.down),
            .halted    (halted),
            .state     (st.state),
            .count     (st.cnt),
            .in_lvl    (st.in_s2),
            .in_rise   (in_rise),
            .in_fall   (in_fall),
            .out_lvl   (st.outv),
            .hit       (hit[e])
        );
    end

    for (genvar o = 0; o < setm_pkg::NOUT; o++) begin : g_out
        setm_outbit u_out (
            .cfg  (st.outcfg[o]),
            .hits (hit),
            .cur  (st.outv[o]),
            .lvl  (out_lvl[o]),
            .chg  (out_chg[o])
        );
    end

    // =========================================================
    // Counter step: returns new direction above the new value
    function automatic logic [32:0] step(
        input logic [31:0] v,
        input logic        down,
        input logic        ud,
        input logic        lim
    );
        logic nd;
        nd = down && ud;
        if (lim && !ud) begin
            return {1'b0, 32'h0000_0000};
        end
        if (lim) begin
            nd = !down;
        end else if (ud && down && v == 32'h0000_0000) begin
            nd = 1'b0;
        end
        return {nd, nd ? v - 32'h0000_0001 : v + 32'h0000_0001};
    endfunction

    // =========================================================
    // Next state
    always_comb begin
        logic [1:0][setm_pkg::NEV-1:0]  hc;
        logic [1:0][3:0]                acts;
        logic [1:0]                     run;
        logic [32:0]                    sv;
        logic [3:0]                     oidx;
        logic [setm_pkg::NEV-1:0]       evh;
        logic [2:0]                     i;
        hc      = '0;
        acts    = '0;
        run     = '0;
        sv      = '0;
        evh     = '0;
        i       = addr[2:0];
        oidx    = {1'b1, addr[2:0]};
        next_st = st;
        next_st.rdata = 32'h0000_0000;

        // Pin synchronisers
        next_st.in_s1   = in_pin;
        next_st.in_s2   = st.in_s1;
        next_st.in_prev = st.in_s2;

        // Split events by counter
        for (int e = 0; e < setm_pkg::NEV; e++) begin
            evh[e] = !unify && st.evctl[e].hctr;
        end
        hc[0] = hit & ~evh;
        hc[1] = hit & evh;

        // Software writes first so hardware events override them
        if (wr) begin
            case (addr)
                setm_pkg::A_CTRL: next_st.ctrl = wdata[6:0];
                setm_pkg::A_STATE: begin
                    for (int c = 0; c < 2; c++) begin
                        if (st.ctrl[setm_pkg::C_HALT + c]) begin
                            next_st.state[c] = wdata[c * setm_pkg::STATE_H +: setm_pkg::SW];
                        end
                    end
                end
                setm_pkg::A_OUT:   next_st.outv  = wdata[setm_pkg::NOUT-1:0];
                setm_pkg::A_FLAG:  next_st.flag  = st.flag & ~wdata[7:0];
                setm_pkg::A_INTEN: next_st.inten = wdata[7:0];
                setm_pkg::A_LIMIT: next_st.act[setm_pkg::ACT_LIMIT] = wdata[15:0];
                setm_pkg::A_STOP:  next_st.act[setm_pkg::ACT_STOP]  = wdata[15:0];
                setm_pkg::A_START: next_st.act[setm_pkg::ACT_START] = wdata[15:0];
                setm_pkg::A_HALT:  next_st.act[setm_pkg::ACT_HALT]  = wdata[15:0];
                default: begin
                    case (addr[7:3])
                        setm_pkg::G_EVST:   next_st.evst[i]   = wdata;
                        setm_pkg::G_EVCTL:  next_st.evctl[i]  = wdata[19:0];
                        setm_pkg::G_MATCH:  next_st.match[i]  = wdata;
                        setm_pkg::G_CAPCTL: next_st.capctl[i] = wdata[8:0];
                        setm_pkg::G_OUTA:   next_st.outcfg[i] = wdata[25:0];
                        setm_pkg::G_OUTB: begin
                            if (oidx < 4'(setm_pkg::NOUT)) begin
                                next_st.outcfg[oidx] = wdata[25:0];
                            end
                        end
                        default: ;
                    endcase
                end
            endcase
        end

        // Counter actions from events
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 4; k++) begin
                acts[c][k] = |(hc[c] & st.act[k][c]);
            end
            run[c] = !st.ctrl[setm_pkg::C_STOP + c] && !halted[c];
            if (acts[c][setm_pkg::ACT_START] && st.ctrl[setm_pkg::C_STOP + c]) begin
                next_st.ctrl[setm_pkg::C_STOP + c] = 1'b0;
            end
            if (acts[c][setm_pkg::ACT_STOP]) begin
                next_st.ctrl[setm_pkg::C_STOP + c] = 1'b1;
            end
            // Halt wins over a software clear in the same cycle
            if (acts[c][setm_pkg::ACT_HALT]) begin
                next_st.ctrl[setm_pkg::C_HALT + c] = 1'b1;
            end
        end

        // Counting
        if (unify) begin
            if (run[0]) begin
                sv = step({st.cnt[1], st.cnt[0]}, st.down[0],
                          st.ctrl[setm_pkg::C_UD], acts[0][setm_pkg::ACT_LIMIT]);
                next_st.cnt[0]  = sv[15:0];
                next_st.cnt[1]  = sv[31:16];
                next_st.down[0] = sv[32];
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (run[c]) begin
                    // Sixteen-bit wrap falls out of the low half
                    sv = step({16'h0000, st.cnt[c]}, st.down[c],
                              st.ctrl[setm_pkg::C_UD + c], acts[c][setm_pkg::ACT_LIMIT]);
                    if (st.down[c] && !acts[c][setm_pkg::ACT_LIMIT] && st.cnt[c] == 16'h0000
                        && !st.ctrl[setm_pkg::C_UD + c]) begin
                        sv = {1'b0, 32'h0000_0001};
                    end
                    next_st.cnt[c]  = sv[15:0];
                    next_st.down[c] = sv[32];
                end
            end
        end

        // State transition from the highest event of each counter
        for (int c = 0; c < 2; c++) begin
            if (|hc[c]) begin
                for (int e = 0; e < setm_pkg::NEV; e++) begin
                    if (hc[c][e]) begin
                        if (st.evctl[e].ld) begin
                            next_st.state[c] = st.evctl[e].next_state_value;
                        end else begin
                            next_st.state[c] = st.state[c] + st.evctl[e].next_state_value;
                        end
                    end
                end
            end
        end

        // Output levels
        for (int o = 0; o < setm_pkg::NOUT; o++) begin
            if (out_chg[o]) begin
                next_st.outv[o] = out_lvl[o];
            end
        end

        // Capture
        for (int m = 0; m < setm_pkg::NMC; m++) begin
            if (|(hit & st.capctl[m].mask)) begin
                if (unify) begin
                    next_st.cap[m] = {st.cnt[1], st.cnt[0]};
                end else if (st.capctl[m].hctr) begin
                    next_st.cap[m] = {16'h0000, st.cnt[1]};
                end else begin
                    next_st.cap[m] = {16'h0000, st.cnt[0]};
                end
            end
        end

        // Flags: an event in the clearing cycle survives
        next_st.flag = next_st.flag | hit;
        next_st.irq  = |(next_st.flag & next_st.inten);

        // Read data, valid in the cycle after the strobe only
        if (rd) begin
            case (addr)
                setm_pkg::A_CTRL:  next_st.rdata = {23'h000000, st.down, st.ctrl};
                setm_pkg::A_STATE: next_st.rdata = {11'h000, st.state[1], 11'h000, st.state[0]};
                setm_pkg::A_COUNT: next_st.rdata = {st.cnt[1], st.cnt[0]};
                setm_pkg::A_OUT:   next_st.rdata = {22'h000000, st.outv};
                setm_pkg::A_FLAG:  next_st.rdata = {24'h000000, st.flag};
                setm_pkg::A_INTEN: next_st.rdata = {24'h000000, st.inten};
                setm_pkg::A_LIMIT: next_st.rdata = {16'h0000, st.act[setm_pkg::ACT_LIMIT]};
                setm_pkg::A_STOP:  next_st.rdata = {16'h0000, st.act[setm_pkg::ACT_STOP]};
                setm_pkg::A_START: next_st.rdata = {16'h0000, st.act[setm_pkg::ACT_START]};
                setm_pkg::A_HALT:  next_st.rdata = {16'h0000, st.act[setm_pkg::ACT_HALT]};
                default: begin
                    case (addr[7:3])
                        setm_pkg::G_EVST:   next_st.rdata = st.evst[i];
                        setm_pkg::G_EVCTL:  next_st.rdata = {12'h000, st.evctl[i]};
                        setm_pkg::G_MATCH:  next_st.rdata = st.match[i];
                        setm_pkg::G_CAP:    next_st.rdata = st.cap[i];
                        setm_pkg::G_CAPCTL: next_st.rdata = {23'h000000, st.capctl[i]};
                        setm_pkg::G_OUTA:   next_st.rdata = {6'h00, st.outcfg[i]};
                        setm_pkg::G_OUTB: begin
                            if (oidx < 4'(setm_pkg::NOUT)) begin
                                next_st.rdata = {6'h00, st.outcfg[oidx]};
                            end
                        end
                        default: next_st.rdata = 32'h0000_0000;
                    endcase
                end
            endcase
        end
    end

    // =========================================================
    // Registers; both counters start halted
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st      <= '0;
            st.ctrl <= setm_pkg::CTRL_RST;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ---- setm_pkg.sv ----
// Package: constants and types of the state event timer
package setm_pkg;
    // =========================================================
    // Sizes
    localparam int NEV  = 8;
    localparam int NMC  = 8;
    localparam int NOUT = 10;
    localparam int NIN  = 4;
    localparam int SW   = 5;

    // =========================================================
    // Register word addresses
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_STATE = 8'h01;
    localparam logic [7:0] A_COUNT = 8'h02;
    localparam logic [7:0] A_OUT   = 8'h03;
    localparam logic [7:0] A_FLAG  = 8'h04;
    localparam logic [7:0] A_INTEN = 8'h05;
    localparam logic [7:0] A_LIMIT = 8'h06;
    localparam logic [7:0] A_STOP  = 8'h07;
    localparam logic [7:0] A_START = 8'h08;
    localparam logic [7:0] A_HALT  = 8'h09;
    // Banks of eight, selected by address bits 7..3
    localparam logic [4:0] G_EVST   = 5'h02;
    localparam logic [4:0] G_EVCTL  = 5'h03;
    localparam logic [4:0] G_MATCH  = 5'h04;
    localparam logic [4:0] G_CAP    = 5'h05;
    localparam logic [4:0] G_CAPCTL = 5'h06;
    localparam logic [4:0] G_OUTA   = 5'h08;
    localparam logic [4:0] G_OUTB   = 5'h09;

    // =========================================================
    // Control word fields and reset value
    localparam int C_UNIFY = 0;
    localparam int C_UD    = 1;
    localparam int C_STOP  = 3;
    localparam int C_HALT  = 5;
    localparam int STATE_H = 16;
    localparam logic [6:0] CTRL_RST = 7'h60;

    // Index of each counter action mask
    localparam int ACT_LIMIT = 0;
    localparam int ACT_STOP  = 1;
    localparam int ACT_START = 2;
    localparam int ACT_HALT  = 3;

    // =========================================================
    // Types
    typedef enum logic [1:0] {IO_LOW, IO_RISE, IO_FALL, IO_HIGH} setm_iocond_e;
    typedef enum logic [1:0] {DIR_ANY, DIR_UP, DIR_DOWN, DIR_RSV} setm_dir_e;
    typedef enum logic [1:0] {RES_NONE, RES_SET, RES_CLR, RES_TOG} setm_res_e;

    typedef struct packed {
        setm_dir_e    dir;
        logic [SW-1:0] next_state_value;
        logic         ld;
        logic         comb;
        logic         iout;
        logic [3:0]   iosel;
        setm_iocond_e iocond;
        logic         hctr;
        logic [2:0]   msel;
    } setm_evctl_s;

    typedef struct packed {
        setm_res_e       res;
        logic [NEV-1:0]  tog;
        logic [NEV-1:0]  clr;
        logic [NEV-1:0]  set;
    } setm_outcfg_s;

    typedef struct packed {
        logic           hctr;
        logic [NEV-1:0] mask;
    } setm_capctl_s;

    typedef struct packed {
        logic [31:0]                    rdata;
        logic                           irq;
        logic [NOUT-1:0]                outv;
        logic [6:0]                     ctrl;
        logic [1:0]                     down;
        logic [1:0][SW-1:0]             state;
        logic [1:0][15:0]               cnt;
        logic [NEV-1:0]                 flag;
        logic [NEV-1:0]                 inten;
        logic [3:0][1:0][NEV-1:0]       act;
        logic [NEV-1:0][31:0]           evst;
        setm_evctl_s [NEV-1:0]          evctl;
        logic [NMC-1:0][31:0]           match;
        logic [NMC-1:0][31:0]           cap;
        setm_capctl_s [NMC-1:0]         capctl;
        setm_outcfg_s [NOUT-1:0]        outcfg;
        logic [NIN-1:0]                 in_s1;
        logic [NIN-1:0]                 in_s2;
        logic [NIN-1:0]                 in_prev;
    } setm_state_s;
endpackage

// ---- setm_event.sv ----
// Event detector: match, pin condition, state mask and direction
module setm_event (
    // Event setup
    input  wire setm_pkg::setm_evctl_s           ctl,
    input  wire logic [31:0]                     state_en,
    input  wire logic [31:0]                     match_val,
    // Counter status
    input  wire logic                            unify,
    input  wire logic [1:0]                      updown,
    input  wire logic [1:0]                      down,
    input  wire logic [1:0]                      halted,
    input  wire logic [1:0][setm_pkg::SW-1:0]    state,
    input  wire logic [1:0][15:0]                count,
    // Pin conditions
    input  wire logic [setm_pkg::NIN-1:0]        in_lvl,
    input  wire logic [setm_pkg::NIN-1:0]        in_rise,
    input  wire logic [setm_pkg::NIN-1:0]        in_fall,
    input  wire logic [setm_pkg::NOUT-1:0]       out_lvl,
    // Result
    output logic                                 hit
);
    logic ctr;
    logic mt;
    logic lvl;
    logic rise;
    logic fall;
    logic io_ok;
    logic dir_ok;

    always_comb begin
        ctr = !unify && ctl.hctr;
        if (unify) begin
            mt = ({count[1], count[0]} == match_val);
        end else begin
            mt = (count[ctr] == match_val[15:0]);
        end
        lvl  = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        // Outputs carry no edge history: edges act as levels
        if (ctl.iout) begin
            if (ctl.iosel < 4'(setm_pkg::NOUT)) begin
                lvl  = out_lvl[ctl.iosel];
                rise = lvl;
                fall = !lvl;
            end
        end else if (ctl.iosel < 4'(setm_pkg::NIN)) begin
            lvl  = in_lvl[ctl.iosel[1:0]];
            rise = in_rise[ctl.iosel[1:0]];
            fall = in_fall[ctl.iosel[1:0]];
        end
        unique case (ctl.iocond)
            setm_pkg::IO_LOW:  io_ok = !lvl;
            setm_pkg::IO_RISE: io_ok = rise;
            setm_pkg::IO_FALL: io_ok = fall;
            setm_pkg::IO_HIGH: io_ok = lvl;
        endcase
        dir_ok = 1'b1;
        if (updown[ctr]) begin
            case (ctl.dir)
                setm_pkg::DIR_UP:   dir_ok = !down[ctr];
                setm_pkg::DIR_DOWN: dir_ok = down[ctr];
                default:            dir_ok = 1'b1;
            endcase
        end
        hit = !halted[ctr]
              && state_en[state[ctr]]
              && mt && (!ctl.comb || io_ok)
              && dir_ok;
    end
endmodule

// ---- setm_outbit.sv ----
// Output action resolver for one output
module setm_outbit (
    // Setup and events
    input  wire setm_pkg::setm_outcfg_s      cfg,
    input  wire logic [setm_pkg::NEV-1:0]    hits,
    input  wire logic                        cur,
    // Result
    output logic                             lvl,
    output logic                             chg
);
    logic s;
    logic c;
    logic t;

    always_comb begin
        s   = |(hits & cfg.set);
        c   = |(hits & cfg.clr);
        t   = |(hits & cfg.tog);
        lvl = cur;
        chg = s || c || t;
        if (s && c) begin
            unique case (cfg.res)
                setm_pkg::RES_NONE: lvl = cur;
                setm_pkg::RES_SET:  lvl = 1'b1;
                setm_pkg::RES_CLR:  lvl = 1'b0;
                setm_pkg::RES_TOG:  lvl = !cur;
            endcase
        end else if (s) begin
            lvl = 1'b1;
        end else if (c) begin
            lvl = 1'b0;
        end else if (t) begin
            lvl = !cur;
        end
    end
endmodule

// ---- setm_assertions.sv ----
// Checker: port-level properties of the state event timer
module setm_chk (
    // Clock and reset
    input wire logic                       mclk,
    input wire logic                       resetn,
    // Register port
    input wire logic [7:0]                 addr,
    input wire logic [31:0]                wdata,
    input wire logic                       wr,
    input wire logic                       rd,
    input wire logic [31:0]                rdata,
    // Timer pins
    input wire logic [setm_pkg::NIN-1:0]   in_pin,
    input wire logic [setm_pkg::NOUT-1:0]  out_pin,
    input wire logic                       irq
);
    // Both halt bits written by software; only software clears them, so this never overstates
    logic halt_seen;
    logic next_halt_seen;

    always_comb begin
        next_halt_seen = halt_seen;
        if (wr && addr == setm_pkg::A_CTRL) begin
            next_halt_seen = wdata[6:5] == 2'h3;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            halt_seen <= 1'b1;
        end else begin
            halt_seen <= next_halt_seen;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    // =========================================================
    // Properties
    AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("Read data not idle");
    AST_RST_QUIET: assert property ($rose(resetn) |-> out_pin == '0 && !irq && rdata == 32'h0)
        else $error("Outputs active at reset release");
    AST_IRQ_MASK: assert property (wr && addr == setm_pkg::A_INTEN && wdata[7:0] == 8'h00 |=> !irq)
        else $error("Interrupt high with all enables off");
    AST_IRQ_CLR: assert property (halt_seen && wr && addr == setm_pkg::A_FLAG && wdata[7:0] == 8'hff |=> !irq)
        else $error("Interrupt stays after flags cleared");
    AST_OUT_WR: assert property (halt_seen && wr && addr == setm_pkg::A_OUT |=> out_pin == $past(wdata[9:0]))
        else $error("Output write not applied");
    AST_HALT_QUIET: assert property (halt_seen && !(wr && addr == setm_pkg::A_OUT) |=> $stable(out_pin))
        else $error("Output moved while halted");
    AST_STATE_WR: assert property (halt_seen && wr && addr == setm_pkg::A_STATE ##1 rd && addr == setm_pkg::A_STATE
        |=> rdata[4:0] == $past(wdata[4:0], 2) && rdata[20:16] == $past(wdata[20:16], 2))
        else $error("State write under halt not read back");
    AST_CNT_FROZEN: assert property (halt_seen && rd && addr == setm_pkg::A_COUNT ##2 halt_seen && rd
        && addr == setm_pkg::A_COUNT |=> rdata == $past(rdata, 2))
        else $error("Count moved while halted");
endmodule

bind setm_top setm_chk u_chk (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                             .rdata(rdata), .in_pin(in_pin), .out_pin(out_pin), .irq(irq));

// ---- state_event_timer_test.sv ----
// Testbench: register-driven scenarios for the state event timer
module state_event_timer_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [3:0]  in_pin = 4'h0;
    logic [31:0] rdata;
    logic [9:0]  out_pin;
    logic        irq;
    int          err_total = 0;
    int          total_checks = 0;
    // Matches, state masks, event setups, output setups, action masks, capture setup, interrupt enable, then preset outputs and state
    localparam logic [7:0]  cfg_a [20] = '{8'h20, 8'h21, 8'h22, 8'h10, 8'h11, 8'h12, 8'h18, 8'h19, 8'h1a, 8'h40,
        8'h41, 8'h42, 8'h43, 8'h44, 8'h07, 8'h08, 8'h30, 8'h05, 8'h03, 8'h01};
    localparam logic [31:0] cfg_d [20] = '{32'h5, 32'h5, 32'h6, 32'h8, 32'h8, 32'h400, 32'h5000, 32'he001,
        32'h13002, 32'h1, 32'h200, 32'h10000, 32'h3000201, 32'h4, 32'h2, 32'h4, 32'h1, 32'h1, 32'h2, 32'h3};

    always #10 mclk = ~mclk;

    setm_top dut (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                  .rdata(rdata), .in_pin(in_pin), .out_pin(out_pin), .irq(irq));

    // =========================================================
    // Bus and report tasks
    task automatic end_sim();
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobe left high so back-to-back writes never assign it twice in one step
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        wr <= 1'b1;
        rd <= 1'b0;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        wr <= 1'b0;
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        chk(rdata, exp);
        @(posedge mclk);
    endtask

    // =========================================================
    // Scenarios
    task automatic run_reset();
        rd_reg(setm_pkg::A_CTRL, 32'h60);
        rd_reg(setm_pkg::A_STATE, 32'h0);
        rd_reg(setm_pkg::A_OUT, 32'h0);
    endtask

    // Two events match together in state 3; the higher one adds, then a third restarts
    task automatic run_events();
        int i;
        for (i = 0; i < 20; i++) begin
            wr_reg(cfg_a[i], cfg_d[i]);
        end
        wr_reg(setm_pkg::A_CTRL, 32'h40);
        wr <= 1'b0;
        for (i = 0; i < 60; i++) begin
            @(negedge mclk);
            if (out_pin[4] === 1'b1) begin
                break;
            end
        end
        if (i == 60) begin
            err_total++;
            end_sim();
        end
        chk({22'h0, out_pin}, 32'h1d);
        chk({31'h0, irq}, 32'h1);
        @(posedge mclk);
        wr_reg(setm_pkg::A_CTRL, 32'h60);
        rd_reg(setm_pkg::A_CTRL, 32'h60);
        rd_reg(setm_pkg::A_STATE, 32'h9);
        rd_reg(8'h28, 32'h5);
        // Low counter stopped at 6, restarted, then two steps before the halt lands
        rd_reg(setm_pkg::A_COUNT, 32'h0000_0008);
        rd_reg(setm_pkg::A_COUNT, 32'h0000_0008);
        rd_reg(setm_pkg::A_FLAG, 32'h7);
        wr_reg(setm_pkg::A_FLAG, 32'hff);
        wr_reg(setm_pkg::A_INTEN, 32'h0);
        rd_reg(setm_pkg::A_FLAG, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic run_state();
        wr_reg(setm_pkg::A_STATE, 32'h0015001f);
        rd_reg(setm_pkg::A_STATE, 32'h0015001f);
        wr_reg(setm_pkg::A_CTRL, 32'h40);
        wr_reg(setm_pkg::A_STATE, 32'h00030003);
        rd_reg(setm_pkg::A_STATE, 32'h0003001f);
        wr_reg(setm_pkg::A_CTRL, 32'h60);
    endtask

    task automatic run_outputs();
        wr_reg(setm_pkg::A_OUT, 32'h3ff);
        rd_reg(setm_pkg::A_OUT, 32'h3ff);
        chk({22'h0, out_pin}, 32'h3ff);
        rd_reg(8'h4a, 32'h0);
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        run_reset();
        run_events();
        run_state();
        run_outputs();
        end_sim();
    end
endmodule
